// [hw/sps_pkg.sv]
// Package: constants and types for the serial shift port.
`default_nettype none
package sps_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;
	localparam int ADDR_W = 8;
	localparam int IRQ_W = 3;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_BUF = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h14;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int STAT_EN_BIT = 15;
	localparam int STAT_SIDL_BIT = 13;
	localparam int STAT_OVF_BIT = 6;
	localparam int STAT_TBF_BIT = 1;
	localparam int STAT_RBF_BIT = 0;
	localparam int CTRL_MSTR_BIT = 0;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_TX_BIT = 1;
	localparam int IRQ_OVF_BIT = 2;
	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int SCK_HALF_NS = 500;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int HALF_W = 4;
	// Transfer sequencer states
	typedef enum logic [1:0] {XS_IDLE, XS_SHIFT, XS_TAIL} sps_xfer_t;
endpackage
`default_nettype wire

// [hw/sps_sync.sv]
// Two-flop synchroniser for pin inputs.
`default_nettype none
module sps_sync
	import sps_pkg::*;
#(
	parameter int W = 3
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// First stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge aclk)
			begin
				meta_r[i] <= aresetn ? async_in[i] : 1'b0;
				sync_r[i] <= aresetn ? meta_r[i] : 1'b0;
			end
		end
	endgenerate
	assign sync_out = sync_r;
endmodule
`default_nettype wire

// [hw/sps_sckgen.sv]
// Shift clock generator for master mode.
`default_nettype none
module sps_sckgen
	import sps_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic run,
	// Generated clock and its edges
	output logic sck,
	output logic rise,
	output logic fall
);
	logic [HALF_W-1:0] cnt_r;
	logic sck_r;
	logic flip;

	// Toggle each half period; reset low and held while stopped, so a word starts clean only after a completed one
	assign flip = run && (cnt_r == HALF_W'(SCK_HALF_CYC - 1));
	assign rise = flip && !sck_r;
	assign fall = flip && sck_r;
	assign sck = sck_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
			cnt_r <= '0;
		else
			cnt_r <= flip ? '0 : cnt_r + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sck_r <= 1'b0;
		else if (flip)
			sck_r <= !sck_r;
	end
endmodule
`default_nettype wire

// [hw/sps_port.sv]
// Serial shift port: AXI4-Lite registers, shift engine, interrupts.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module sps_port
	import sps_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Processor idle indication
	input wire logic cpu_idle,
	// Serial pins
	input wire logic shift_clock_pin_i,
	output logic shift_clock_pin_o,
	output logic shift_clock_oe_n,
	input wire logic serial_data_in,
	output logic serial_data_out,
	input wire logic slave_select_n,
	// Interrupt
	output logic irq
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic aw_r, w_r, bvalid_r, rvalid_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic en_r, sidl_r, mstr_r, ovf_r, tbf_r, rbf_r, out_r;
	logic [WORD_W-1:0] tx_hold_r, rx_hold_r, sr_r;
	logic [CNT_W-1:0] cnt_r;
	logic [IRQ_W-1:0] ist_r, ien_r;
	sps_xfer_t st_r, st_nxt;
	logic [2:0] pin_s;
	logic sck_s, sdi_s, ss_s, sck_d_r;
	logic gen_sck, gen_rise, gen_fall, gen_run;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire wr_go = aw_r && w_r && !bvalid_r;
	wire wr_map = hit(awaddr_r, ADDR_STAT) || hit(awaddr_r, ADDR_BUF)
		|| hit(awaddr_r, ADDR_CTRL) || hit(awaddr_r, ADDR_IRQ_ST)
		|| hit(awaddr_r, ADDR_IRQ_CLR) || hit(awaddr_r, ADDR_IRQ_EN);
	wire lane0 = wstrb_r[0];
	wire lane1 = wstrb_r[1];
	wire wr_stat = wr_go && hit(awaddr_r, ADDR_STAT);
	wire wr_buf = wr_go && hit(awaddr_r, ADDR_BUF) && (lane0 || lane1);
	wire wr_ctrl = wr_go && hit(awaddr_r, ADDR_CTRL) && lane0;
	wire wr_iclr = wr_go && hit(awaddr_r, ADDR_IRQ_CLR) && lane0;
	wire wr_ien = wr_go && hit(awaddr_r, ADDR_IRQ_EN) && lane0;
	wire ar_go = arvalid && !rvalid_r;
	wire rd_buf = ar_go && hit(araddr, ADDR_BUF);
	// Byte lanes merge into the transmit word
	wire [WORD_W-1:0] tx_wr = {lane1 ? wdata_r[15:8] : tx_hold_r[15:8],
		lane0 ? wdata_r[7:0] : tx_hold_r[7:0]};
	// Unimplemented status bits read as zero
	wire [WORD_W-1:0] stat_word = (WORD_W'(en_r) << STAT_EN_BIT)
		| (WORD_W'(sidl_r) << STAT_SIDL_BIT) | (WORD_W'(ovf_r) << STAT_OVF_BIT)
		| (WORD_W'(tbf_r) << STAT_TBF_BIT) | (WORD_W'(rbf_r) << STAT_RBF_BIT);
	wire [31:0] rd_word =
		hit(araddr, ADDR_STAT) ? {16'h0000, stat_word} :
		hit(araddr, ADDR_BUF) ? {16'h0000, rx_hold_r} :
		hit(araddr, ADDR_CTRL) ? {31'h00000000, mstr_r} :
		hit(araddr, ADDR_IRQ_ST) ? {29'h00000000, ist_r} :
		hit(araddr, ADDR_IRQ_EN) ? {29'h00000000, ien_r} : 32'h00000000;
	wire rd_map = hit(araddr, ADDR_STAT) || hit(araddr, ADDR_BUF)
		|| hit(araddr, ADDR_CTRL) || hit(araddr, ADDR_IRQ_ST)
		|| hit(araddr, ADDR_IRQ_CLR) || hit(araddr, ADDR_IRQ_EN);

	assign awready = !aw_r && !bvalid_r;
	assign wready = !w_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// Write channels taken in either order, answered once both are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (wr_go)
			begin
				aw_r <= 1'b0;
				w_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid_r <= 1'b0;
		end
	end

	// Read answered the cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end
		else if (ar_go)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Pins and shift clock edges
	// ----------------------------------------------------------------
	sps_sync #(.W(3)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({shift_clock_pin_i, serial_data_in, slave_select_n}),
		.sync_out(pin_s)
	);
	assign sck_s = pin_s[2];
	assign sdi_s = pin_s[1];
	assign ss_s = pin_s[0];

	wire run = en_r && !(sidl_r && cpu_idle);
	wire busy = st_r != XS_IDLE;
	assign gen_run = run && mstr_r && busy;
	sps_sckgen u_sckgen (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(gen_run),
		.sck(gen_sck),
		.rise(gen_rise),
		.fall(gen_fall)
	);

	// Slave edges only count while selected
	wire sl_act = run && !mstr_r && !ss_s;
	wire sl_rise = sl_act && sck_s && !sck_d_r;
	wire sl_fall = sl_act && !sck_s && sck_d_r;
	wire rise = mstr_r ? gen_rise : sl_rise;
	wire fall = mstr_r ? gen_fall : sl_fall;
	wire last = rise && (cnt_r == LAST_BIT);
	wire sl_abort = !mstr_r && ss_s && busy;

	// Master drives the clock pin; slave leaves it to the partner
	assign shift_clock_pin_o = en_r && mstr_r && gen_sck;
	assign shift_clock_oe_n = !(en_r && mstr_r);
	assign serial_data_out = en_r && out_r;

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	wire load = run && (st_r == XS_IDLE) && tbf_r
		&& (mstr_r || !ss_s || st_nxt == XS_SHIFT);
	wire done = run && (mstr_r ? (st_r == XS_TAIL && fall)
		: (st_r == XS_SHIFT && last));
	wire [WORD_W-1:0] sr_in = {sr_r[WORD_W-2:0], sdi_s};
	// Master ends on the tail fall with the word already shifted in
	wire [WORD_W-1:0] rx_word = mstr_r ? sr_r : sr_in;

	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			XS_IDLE:
				if (tbf_r || (!mstr_r && !ss_s))
					st_nxt = XS_SHIFT;
			XS_SHIFT:
				if (last)
					st_nxt = mstr_r ? XS_TAIL : XS_IDLE;
			XS_TAIL:
				if (fall)
					st_nxt = XS_IDLE;
		endcase
		if (!en_r || sl_abort)
			st_nxt = XS_IDLE;
		else if (!run)
			st_nxt = st_r;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= XS_IDLE;
		else
			st_r <= st_nxt;
	end

	// Sample on rising edges, present next bit on falling edges
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sr_r <= WORD_RST;
			cnt_r <= '0;
			out_r <= 1'b0;
			sck_d_r <= 1'b0;
		end
		else
		begin
			sck_d_r <= sck_s;
			if (load)
			begin
				sr_r <= tx_hold_r;
				out_r <= tx_hold_r[WORD_W-1];
				cnt_r <= '0;
			end
			else if (!en_r || sl_abort || st_nxt == XS_IDLE)
				cnt_r <= '0;
			else if (rise)
			begin
				sr_r <= sr_in;
				cnt_r <= cnt_r + 1'b1;
			end
			else if (fall && st_r == XS_SHIFT)
				out_r <= sr_r[WORD_W-1];
		end
	end

	// ----------------------------------------------------------------
	// Control and status
	// ----------------------------------------------------------------
	wire ovf_set = done && rbf_r && !rd_buf;
	wire rx_set = done && !ovf_set;
	wire ovf_clr = wr_stat && lane0 && !wdata_r[STAT_OVF_BIT];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			en_r <= 1'b0;
			sidl_r <= 1'b0;
			mstr_r <= 1'b0;
			ovf_r <= 1'b0;
			tbf_r <= 1'b0;
			rbf_r <= 1'b0;
			tx_hold_r <= WORD_RST;
			rx_hold_r <= WORD_RST;
		end
		else
		begin
			if (wr_stat && lane1)
			begin
				en_r <= wdata_r[STAT_EN_BIT];
				sidl_r <= wdata_r[STAT_SIDL_BIT];
			end
			if (wr_ctrl)
				mstr_r <= wdata_r[CTRL_MSTR_BIT];
			// Hardware set wins over software clear
			ovf_r <= ovf_set || (ovf_r && !ovf_clr);
			if (wr_buf)
				tx_hold_r <= tx_wr;
			tbf_r <= wr_buf || (tbf_r && !load);
			// New word is dropped rather than overwriting unread data
			if (rx_set)
				rx_hold_r <= rx_word;
			rbf_r <= rx_set || (rbf_r && !rd_buf);
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	wire [IRQ_W-1:0] iev = (IRQ_W'(rx_set) << IRQ_RX_BIT)
		| (IRQ_W'(load) << IRQ_TX_BIT) | (IRQ_W'(ovf_set) << IRQ_OVF_BIT);
	wire [IRQ_W-1:0] iclr = wr_iclr ? wdata_r[IRQ_W-1:0] : IRQ_RST;
	assign irq = |(ist_r & ien_r);

	// Events win over a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ist_r <= IRQ_RST;
			ien_r <= IRQ_RST;
		end
		else
		begin
			ist_r <= iev | (ist_r & ~iclr);
			if (wr_ien)
				ien_r <= wdata_r[IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_TBF_SET: assert property (wr_buf |=> tbf_r)
		else $error("transmit-full not set by buffer write");
	AST_TBF_CLR: assert property ((load && !wr_buf) |=> !tbf_r
		&& sr_r == $past(tx_hold_r))
		else $error("transmit-full not cleared on load");
	AST_RBF_SET: assert property ((done && !rbf_r) |=> rbf_r
		&& rx_hold_r == $past(rx_word))
		else $error("completed word not moved to receive buffer");
	AST_OVF: assert property ((done && rbf_r && !rd_buf) |=> ovf_r
		&& $stable(rx_hold_r))
		else $error("overflow not flagged or word not discarded");
	AST_SCK_DIR: assert property ((en_r && mstr_r) == !shift_clock_oe_n)
		else $error("shift clock direction wrong");
	AST_SLAVE_IN: assert property ((!mstr_r) |-> shift_clock_oe_n
		&& !shift_clock_pin_o)
		else $error("slave drives the shift clock");
	AST_IDLE_HALT: assert property ((en_r && sidl_r && cpu_idle)
		|=> $stable(sr_r) && $stable(cnt_r))
		else $error("port moved while halted in idle");
	AST_DISABLE: assert property (!en_r |=> st_r == XS_IDLE
		&& !serial_data_out)
		else $error("disabled port still active");
	AST_SS_DESEL: assert property ((run && !mstr_r && ss_s) |=> cnt_r == 0)
		else $error("deselected slave counted bits");
	AST_WORD_LEN: assert property (done |-> cnt_r == LAST_BIT
		|| (mstr_r && cnt_r == LAST_BIT + 1'b1))
		else $error("word length not sixteen bits");
	AST_RESET: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> stat_word == 0
		&& ist_r == 0 && !bvalid && !rvalid)
		else $error("state not cleared by reset");

	COV_MASTER: cover property (done && mstr_r);
	COV_SLAVE: cover property (done && !mstr_r);
	COV_OVF: cover property (ovf_set);
	COV_HALT: cover property (busy && sidl_r && cpu_idle);
endmodule
`default_nettype wire

// [tb/sps_partner.sv]
// Behavioural far-side serial partner for the shift port bench.
`default_nettype none
module sps_partner
(
	// Line levels seen and driven
	input wire logic sck,
	input wire logic sdo,
	output logic sdi,
	output logic sck_drv,
	output logic ss_n,
	// Last word captured from the port
	output logic [15:0] rx_word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] sh;
	int n;
	// ----------------------------------------------------------------
	// Line handling
	// ----------------------------------------------------------------
	// Idle: clock low, select high (pull-up level), no word armed
	initial
	begin
		sck_drv = 1'b0;
		ss_n = 1'b1;
		sdi = 1'b0;
		rx_word = 16'h0000;
		n = 16;
	end
	// Capture on rising edge, first bit is bit 15
	always @(posedge sck)
		if (n < 16)
		begin
			rx_word = {rx_word[14:0], sdo};
			n = n + 1;
		end
	// Next bit after falling edge; a released line flips so no stale bit
	always @(negedge sck)
		if (n < 16)
		begin
			sh = sh << 1;
			sdi = sh[15];
		end
		else
			sdi = ~sdi;
	// First bit must be on the line before the first rising edge
	task automatic arm(input logic [15:0] w);
		sh = w;
		sdi = w[15];
		n = 0;
	endtask
	// One frame at 800 ns link period, clock still outside it
	task automatic frame(input logic [15:0] w, input logic sel);
		arm(w);
		#37;
		ss_n = ~sel;
		#400;
		repeat (16)
		begin
			sck_drv = 1'b1;
			#400;
			sck_drv = 1'b0;
			#400;
		end
		ss_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the serial shift port.
`default_nettype none
module tb_top
	import sps_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic cpu_idle, awready, wready, bvalid, arready, rvalid, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic sck_o, sck_oe_n, sck_w, sdi, sdo, ss_n, p_sck;
	logic [15:0] p_rx, w, p;
	logic [15:0] q[2];
	logic [1:0] wq[$];
	logic [33:0] rq[$];
	logic [7:0] regs[5] = '{ADDR_STAT, ADDR_BUF, ADDR_CTRL, ADDR_IRQ_ST,
		ADDR_IRQ_EN};
	int bad_count, num_checks;
	// Wire level of the clock pin, picked by the port's output enable alone
	assign sck_w = sck_oe_n ? p_sck : sck_o;
	sps_port dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cpu_idle,
		.shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
		.shift_clock_oe_n(sck_oe_n), .serial_data_in(sdi),
		.serial_data_out(sdo), .slave_select_n(ss_n), .irq);
	sps_partner part_u (.sck(sck_w), .sdo(sdo), .sdi(sdi), .sck_drv(p_sck),
		.ss_n(ss_n), .rx_word(p_rx));
	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic results();
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp_w(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp_r(input string nm, input logic [1:0] e,
		input logic [1:0] g);
		cmp_w(nm, {30'h0, e}, {30'h0, g});
	endtask
	task automatic cmp_b(input string nm, input logic e, input logic g);
		cmp_w(nm, {31'h0, e}, {31'h0, g});
	endtask
	// Every wait is bounded; running out ends the run as a failure
	task automatic guard(inout int k);
		k++;
		if (k > 600)
		begin
			bad_count++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int k;
		logic pa, pw;
		@(posedge aclk);
		wq.push_back(e);
		k = 0;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			guard(k);
			if (pa && awready)
			begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready)
			begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (pa || pw);
		do
		begin
			@(posedge aclk);
			guard(k);
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int k;
		@(posedge aclk);
		rq.push_back({e, d});
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			guard(k);
		end
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			guard(k);
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// Answers are matched in order against the noted expectations
	always @(posedge aclk)
	begin
		if (bvalid && bready)
			cmp_r("bresp", wq.pop_front(), bresp);
		if (rvalid && rready)
		begin
			cmp_w("rdata", rq[0][31:0], rdata);
			cmp_r("rresp", rq[0][33:32], rresp);
			void'(rq.pop_front());
		end
	end
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq !== 1'b1)
		begin
			@(posedge aclk);
			guard(k);
		end
	endtask
	// Master word; hold keeps the processor idle to show the freeze
	task automatic mxfer(input logic [15:0] pw, input logic hold);
		logic [15:0] tw;
		tw = 16'($urandom);
		part_u.arm(pw);
		wr(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
		wr(ADDR_BUF, {16'h0, tw}, RESP_OKAY);
		if (hold)
		begin
			repeat (250) @(posedge aclk);
			cmp_b("irq", 1'b0, irq);
			cpu_idle <= 1'b0;
		end
		wait_irq();
		cmp_w("link", {16'h0, tw}, {16'h0, p_rx});
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		cpu_idle = 1'b0;
		bad_count = 0;
		num_checks = 0;
		void'($urandom(32'h9907));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (regs[i])
			rd(regs[i], 32'h0, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'hffff, RESP_SLVERR);
		wr(ADDR_STAT, 32'hffffffff, RESP_OKAY);
		rd(ADDR_STAT, 32'ha000, RESP_OKAY);
		wr(ADDR_STAT, 32'h0, RESP_OKAY);
		rd(ADDR_STAT, 32'h0, RESP_OKAY);
		// Idle processor keeps the port running while the bit is clear
		cpu_idle <= 1'b1;
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wr(ADDR_IRQ_EN, 32'h5, RESP_OKAY);
		p = 16'($urandom);
		w = 16'($urandom);
		part_u.arm(p);
		wr(ADDR_BUF, {16'h0, w}, RESP_OKAY);
		rd(ADDR_STAT, 32'h2, RESP_OKAY);
		cmp_b("oe_n", 1'b1, sck_oe_n);
		wr(ADDR_STAT, 32'h8000, RESP_OKAY);
		wait_irq();
		cmp_b("oe_n", 1'b0, sck_oe_n);
		cmp_w("link", {16'h0, w}, {16'h0, p_rx});
		rd(ADDR_STAT, 32'h8001, RESP_OKAY);
		wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
		rd(ADDR_IRQ_ST, 32'h3, RESP_OKAY);
		cmp_b("irq", 1'b0, irq);
		wr(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
		wr(ADDR_IRQ_EN, 32'h5, RESP_OKAY);
		rd(ADDR_IRQ_ST, 32'h0, RESP_OKAY);
		cmp_b("irq", 1'b0, irq);
		rd(ADDR_BUF, {16'h0, p}, RESP_OKAY);
		rd(ADDR_STAT, 32'h8000, RESP_OKAY);
		// Second word lands on an unread buffer
		for (int i = 0; i < 2; i++)
		begin
			q[i] = 16'($urandom);
			mxfer(q[i], 1'b0);
		end
		rd(ADDR_STAT, 32'h8041, RESP_OKAY);
		rd(ADDR_BUF, {16'h0, q[0]}, RESP_OKAY);
		wstrb <= 4'h1;
		wr(ADDR_STAT, 32'h0, RESP_OKAY);
		wstrb <= 4'hf;
		rd(ADDR_STAT, 32'h8000, RESP_OKAY);
		// Slave mode: unselected frame first, then a selected one
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
		w = 16'($urandom);
		p = 16'($urandom);
		wr(ADDR_BUF, {16'h0, w}, RESP_OKAY);
		cmp_b("oe_n", 1'b1, sck_oe_n);
		part_u.frame(~p, 1'b0);
		rd(ADDR_STAT, 32'h8000, RESP_OKAY);
		part_u.frame(p, 1'b1);
		wait_irq();
		cmp_w("link", {16'h0, w}, {16'h0, p_rx});
		rd(ADDR_BUF, {16'h0, p}, RESP_OKAY);
		// Stop-in-idle set: nothing moves until the processor wakes
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wr(ADDR_STAT, 32'ha000, RESP_OKAY);
		cpu_idle <= 1'b1;
		mxfer(16'($urandom), 1'b1);
		results();
	end
endmodule
`default_nettype wire
